/* logic/pmwc_countdown.sv */
/*
  Loadable down-counter that flags when a wake delay has run out.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pmwc_countdown (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [16:0] value,
  output logic busy,
  output logic done
);
  logic [16:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= 17'h00000;
      done <= 1'b0;
    end else if (load) begin
      cnt_q <= value;
      done <= 1'b0;
    end else if (cnt_q != 17'h00000) begin
      cnt_q <= cnt_q - 17'h00001;
      done <= (cnt_q == 17'h00001);
    end else begin
      done <= 1'b0;
    end
  end

  assign busy = (cnt_q != 17'h00000);
endmodule : pmwc_countdown
`default_nettype wire

/* logic/pmwc_ctrl.sv */
/*
  Power-mode and wake controller: mode sequencing, gating, I/O latch,
  wake collection, reset cause and clock source selection.
  Assumes APB from the CPU side and synchronous inputs on clk.
*/
// What this block does
// - Idle stops CPU and memory clocks only.
// - Any interrupt returns idle to active.
// - Standby keeps always-on; needs pin/RTC/sensor wake.
// - Standby wake resumes CPU; retention kept.
// - Latch all GPIOs on standby entry.
// - Shutdown powers all off but the power-on detector; I/Os stay latched.
// - Shutdown pin change wakes through reset.
// - Reset cause register: pin wake, reset pin, POR.
// - Shutdown keeps only latched I/O and the power-on detector.
// - Wake delays 14, 174, 1015 microseconds.
// - Reset pin wakes all; pin edge not held.
// - Brown-out on active/idle, duty-cycled standby.
// - Power-on detector active in all modes.
// - Brown-out off between standby recharges.
// - Always-on domain off only in shutdown.
// - High-speed from doubled crystal or RC.
// - Low-speed from crystal or RC; pin out.
// - Sensor controller runs; masked events wake CPU.
`timescale 1ns/1ps
`default_nettype none
module pmwc_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_n,
  input wire logic reset_pin_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pmwc_pkg::NIRQ-1:0] irq,
  input wire logic rtc_event,
  input wire logic [pmwc_pkg::NSC-1:0] sc_event,
  input wire logic [pmwc_pkg::NSC-1:0] sc_wake_cfg,
  input wire logic [pmwc_pkg::NPIN-1:0] pin_in,
  input wire logic [pmwc_pkg::NPIN-1:0] pin_wake_cfg,
  input wire logic [pmwc_pkg::NPIN-1:0] gpio_out,
  input wire logic lf_xtal_fitted,
  input wire logic hs_stable,
  input wire logic lf_clk_in,
  output logic [pmwc_pkg::NPIN-1:0] io_latch,
  output logic [pmwc_pkg::NPIN-1:0] io_held,
  output logic cpu_clk_en,
  output logic mem_clk_en,
  output logic periph_clk_en,
  output logic radio_en,
  output logic flash_en,
  output logic sram_pwr_en,
  output logic always_on_domain_en,
  output logic sc_en,
  output logic cpu_halt,
  output logic sys_reset_n,
  output logic high_speed_crystal_osc_en,
  output logic high_speed_rc_osc_en,
  output logic hs_doubler_en,
  output logic hs_sel_rc,
  output logic low_speed_crystal_osc_en,
  output logic low_speed_rc_osc_en,
  output logic lf_gpio_out,
  output logic brownout_detector_en,
  output logic por_detector_en
);
  import pmwc_pkg::*;
  default clocking chk_clk @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------------
  pmwc_state_e state_q;
  pmwc_state_e from_q;
  logic [1:0] cause_q;
  logic [2:0] wmask_q;
  logic hs_rc_q;
  logic lf_out_q;
  logic go_q;
  pmwc_req_e req_q;
  logic [NPIN-1:0] pin_prev_q;
  logic [6:0] bod_cnt_q;
  logic [4:0] hs_cnt_q;
  logic [16:0] load_val;
  logic load, wbusy, wr, pin_edge, sc_wake, any_wake_stby;

  assign wr = psel && penable && pwrite;
  assign pin_edge = |((pin_in ^ pin_prev_q) & pin_wake_cfg);
  assign sc_wake = |(sc_event & sc_wake_cfg);
  assign any_wake_stby = (rtc_event && wmask_q[WMASK_RTC_BIT])
    || (sc_wake && wmask_q[WMASK_SC_BIT])
    || (pin_edge && wmask_q[WMASK_PIN_BIT]);

  pmwc_countdown i_pmwc_countdown (
    .clk(clk),
    .resetn(resetn),
    .load(load),
    .value(load_val),
    .busy(wbusy),
    .done()
  );

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, unmapped addresses answer with an error.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          REG_CTRL: prdata <= {30'h00000000, req_q};
          REG_STATUS: prdata <= {28'h0000000, wbusy, state_q};
          REG_RSTCAUSE: prdata <= {30'h00000000, cause_q};
          REG_WAKEMASK: prdata <= {29'h00000000, wmask_q};
          REG_CLKSEL: prdata <= {30'h00000000, lf_out_q, hs_rc_q};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Writes land when pready is high; power-off clears software state.
  always_ff @(posedge clk) begin
    if (!resetn || state_q == ST_SHUTDOWN || state_q == ST_HELD) begin
      wmask_q <= WMASK_RESET;
      hs_rc_q <= 1'b0;
      lf_out_q <= 1'b0;
      req_q <= REQ_NONE;
      go_q <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (wr && pready) begin
        case (paddr)
          REG_CTRL: begin
            req_q <= pmwc_req_e'(pwdata[CTRL_REQ_LSB +: 2]);
            go_q <= pwdata[CTRL_GO_BIT];
          end
          REG_WAKEMASK: wmask_q <= pwdata[2:0];
          REG_CLKSEL: begin
            hs_rc_q <= pwdata[CLK_HS_RC_BIT];
            lf_out_q <= pwdata[CLK_LF_OUT_BIT];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= pin_in;
    end
  end

  // ----------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    load = 1'b0;
    load_val = 17'h00000;
    case (state_q)
      ST_IDLE: begin
        load = |irq;
        load_val = 17'(WAKE_IDLE_CYC);
      end
      ST_STANDBY: begin
        load = any_wake_stby || !reset_pin_n;
        load_val = 17'(WAKE_STBY_CYC);
      end
      ST_SHUTDOWN: begin
        load = pin_edge;
        load_val = 17'(WAKE_SHDN_CYC);
      end
      ST_HELD: begin
        load = reset_pin_n;
        load_val = 17'(WAKE_SHDN_CYC);
      end
      default: ;
    endcase
  end

  // The power-on detector outranks everything; the reset pin holds the
  // device from any mode, and pin edges are ignored while held.
  always_ff @(posedge clk) begin
    if (!resetn || !por_n) begin
      state_q <= ST_WAKE;
      from_q <= ST_HELD;
      cause_q <= CAUSE_POR;
    end else if (!reset_pin_n) begin
      state_q <= ST_HELD;
      cause_q <= CAUSE_PIN_RESET;
    end else begin
      case (state_q)
        ST_ACTIVE: begin
          if (go_q) begin
            case (req_q)
              REQ_IDLE: state_q <= ST_IDLE;
              REQ_STANDBY: state_q <= ST_STANDBY;
              REQ_SHUTDOWN: state_q <= ST_SHUTDOWN;
              default: ;
            endcase
          end
        end
        ST_IDLE, ST_STANDBY, ST_SHUTDOWN, ST_HELD: begin
          if (load) begin
            from_q <= state_q;
            state_q <= ST_WAKE;
            if (state_q == ST_SHUTDOWN) begin
              cause_q <= CAUSE_SHDN_WAKE;
            end
          end
        end
        ST_WAKE: begin
          if (!wbusy && hs_cnt_q == 5'h00 && hs_stable) begin
            state_q <= ST_ACTIVE;
          end
        end
        default: state_q <= ST_ACTIVE;
      endcase
    end
  end

  // High-speed clock must be stable for a while before CPU release.
  always_ff @(posedge clk) begin
    if (!resetn || state_q != ST_WAKE || !hs_stable) begin
      hs_cnt_q <= 5'(HS_STABLE_CYC);
    end else if (hs_cnt_q != 5'h00) begin
      hs_cnt_q <= hs_cnt_q - 5'h01;
    end
  end

  // Standby brown-out duty cycle: on for a short recharge window only.
  always_ff @(posedge clk) begin
    if (!resetn || state_q != ST_STANDBY) begin
      bod_cnt_q <= 7'h00;
    end else if (bod_cnt_q == 7'(BOD_PERIOD_CYC - 1)) begin
      bod_cnt_q <= 7'h00;
    end else begin
      bod_cnt_q <= bod_cnt_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Gating outputs, all registered
  // ----------------------------------------------------------------------
  logic deep, off;
  assign deep = (state_q == ST_STANDBY) || off;
  assign off = (state_q == ST_SHUTDOWN) || (state_q == ST_HELD);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cpu_clk_en <= 1'b0;
      mem_clk_en <= 1'b0;
      periph_clk_en <= 1'b0;
      radio_en <= 1'b0;
      flash_en <= 1'b0;
      sram_pwr_en <= 1'b1;
      always_on_domain_en <= 1'b1;
      sc_en <= 1'b1;
      cpu_halt <= 1'b1;
      sys_reset_n <= 1'b0;
    end else begin
      cpu_clk_en <= (state_q == ST_ACTIVE);
      mem_clk_en <= (state_q == ST_ACTIVE);
      periph_clk_en <= !deep;
      radio_en <= !deep;
      flash_en <= !deep;
      // SRAM keeps power through standby so the CPU resumes in place.
      sram_pwr_en <= !off;
      always_on_domain_en <= (state_q != ST_SHUTDOWN);
      sc_en <= !off;
      cpu_halt <= (state_q != ST_ACTIVE);
      // A shutdown wake or held reset restarts the core rather than resume.
      sys_reset_n <= !(off || (state_q == ST_WAKE && from_q != ST_IDLE
        && from_q != ST_STANDBY));
    end
  end

  // I/O latch: capture on entry, hold until the wake completes.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      io_latch <= '0;
      io_held <= '0;
    end else if (state_q == ST_ACTIVE && go_q
                 && (req_q == REQ_STANDBY || req_q == REQ_SHUTDOWN)) begin
      io_latch <= gpio_out;
      io_held <= '1;
    end else if (state_q == ST_ACTIVE) begin
      io_latch <= gpio_out;
      io_held <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      high_speed_crystal_osc_en <= 1'b1;
      high_speed_rc_osc_en <= 1'b1;
      hs_doubler_en <= 1'b1;
      hs_sel_rc <= 1'b0;
      low_speed_crystal_osc_en <= 1'b0;
      low_speed_rc_osc_en <= 1'b1;
      lf_gpio_out <= 1'b0;
      brownout_detector_en <= 1'b1;
      por_detector_en <= 1'b1;
    end else begin
      high_speed_crystal_osc_en <= !deep;
      high_speed_rc_osc_en <= !deep && hs_rc_q;
      hs_doubler_en <= !deep;
      hs_sel_rc <= hs_rc_q;
      low_speed_crystal_osc_en <= !off && lf_xtal_fitted;
      low_speed_rc_osc_en <= !off && !lf_xtal_fitted;
      lf_gpio_out <= lf_out_q && !off && lf_clk_in;
      brownout_detector_en <= off ? 1'b0 :
        (state_q == ST_STANDBY) ? (bod_cnt_q < 7'(BOD_ON_CYC)) :
        1'b1;
      por_detector_en <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  chk_idle_cpu_gated: assert property (state_q == ST_IDLE |=>
    !cpu_clk_en && periph_clk_en) else $error("idle did not gate cpu only");
  chk_idle_irq_wake: assert property (state_q == ST_IDLE && |irq
    && por_n && reset_pin_n |=> state_q == ST_WAKE)
    else $error("irq did not leave idle");
  chk_shdn_aon_off: assert property (state_q == ST_SHUTDOWN |=>
    !always_on_domain_en && !sc_en) else $error("always-on on in shutdown");
  chk_stby_hs_off: assert property (state_q == ST_STANDBY |=>
    !high_speed_crystal_osc_en) else $error("high-speed clock on in standby");
  chk_shdn_cause: assert property (state_q == ST_SHUTDOWN && pin_edge
    && por_n && reset_pin_n |=> cause_q == CAUSE_SHDN_WAKE)
    else $error("shutdown wake cause wrong");
  chk_pin_reset_held: assert property (por_n && !reset_pin_n |=>
    state_q == ST_HELD) else $error("reset pin did not hold");
  chk_io_hold: assert property (state_q == ST_STANDBY
    && $past(state_q) == ST_STANDBY |-> $stable(io_latch))
    else $error("latched io moved in standby");
  chk_bod_off: assert property (state_q == ST_SHUTDOWN |=>
    !brownout_detector_en) else $error("brown-out on in shutdown");
  chk_idle_wake_time: assert property (state_q == ST_IDLE ##1
    (state_q == ST_WAKE && from_q == ST_IDLE && reset_pin_n && por_n)
    |-> cpu_halt [*8]) else $error("idle wake released cpu too early");
endmodule : pmwc_ctrl
`default_nettype wire

/* logic/pmwc_pkg.sv */
/*
  Constants, modes and register map of the power-mode and wake controller.
  Assumes a 50 MHz system clock and an APB register bus.
*/
package pmwc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int WAKE_IDLE_US = 14;
  localparam int WAKE_STBY_US = 174;
  localparam int WAKE_SHDN_US = 1015;
  localparam int WAKE_IDLE_CYC = WAKE_IDLE_US * CLK_MHZ;
  localparam int WAKE_STBY_CYC = WAKE_STBY_US * CLK_MHZ;
  localparam int WAKE_SHDN_CYC = WAKE_SHDN_US * CLK_MHZ;
  localparam int HS_STABLE_CYC = 16;
  localparam int BOD_PERIOD_CYC = 64;
  localparam int BOD_ON_CYC = 4;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_RSTCAUSE = 12'h008;
  localparam logic [11:0] REG_WAKEMASK = 12'h00C;
  localparam logic [11:0] REG_CLKSEL = 12'h010;

  // Control fields: request code in [1:0], go strobe in bit 2.
  localparam int CTRL_REQ_LSB = 0;
  localparam int CTRL_GO_BIT = 2;
  // Clock select fields.
  localparam int CLK_HS_RC_BIT = 0;
  localparam int CLK_LF_OUT_BIT = 1;
  // Wake mask fields.
  localparam int WMASK_RTC_BIT = 0;
  localparam int WMASK_SC_BIT = 1;
  localparam int WMASK_PIN_BIT = 2;
  localparam logic [2:0] WMASK_RESET = 3'h7;

  localparam int NPIN = 8;
  localparam int NIRQ = 8;
  localparam int NSC = 4;

  // Reset cause codes.
  localparam logic [1:0] CAUSE_POR = 2'h0;
  localparam logic [1:0] CAUSE_PIN_RESET = 2'h1;
  localparam logic [1:0] CAUSE_SHDN_WAKE = 2'h2;

  typedef enum logic [1:0] {
    REQ_NONE = 2'b00,
    REQ_IDLE = 2'b01,
    REQ_STANDBY = 2'b10,
    REQ_SHUTDOWN = 2'b11
  } pmwc_req_e;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_IDLE = 3'b001,
    ST_STANDBY = 3'b010,
    ST_SHUTDOWN = 3'b011,
    ST_HELD = 3'b100,
    ST_WAKE = 3'b101
  } pmwc_state_e;

endpackage : pmwc_pkg

/* verif/pmwc_partner.sv */
/*
  Behavioural far side of the controller: high-speed oscillators that need
  time to settle after enable, and the low-speed clock source.
  Assumes the controller drives its oscillator enables from clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pmwc_partner #(
  parameter int SETTLE_CYC = 10,
  parameter int LF_HALF_CYC = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic high_speed_crystal_osc_en,
  input wire logic hs_doubler_en,
  input wire logic high_speed_rc_osc_en,
  input wire logic low_speed_crystal_osc_en,
  input wire logic low_speed_rc_osc_en,
  output logic hs_stable,
  output logic lf_clk_in
);
  logic hs_run;
  logic lf_run;
  logic [7:0] settle_q;
  logic [7:0] lf_cnt_q;

  // A started crystal is not usable at once, so a wake must wait for it.
  assign hs_run = (high_speed_crystal_osc_en & hs_doubler_en) |
                  high_speed_rc_osc_en;
  assign lf_run = low_speed_crystal_osc_en | low_speed_rc_osc_en;
  assign hs_stable = (settle_q == 8'(SETTLE_CYC));

  always_ff @(posedge clk) begin
    if (!resetn || !hs_run) begin
      settle_q <= 8'h00;
    end else if (settle_q != 8'(SETTLE_CYC)) begin
      settle_q <= settle_q + 8'h01;
    end
  end

  // A stopped low-speed oscillator leaves its line flat.
  always_ff @(posedge clk) begin
    if (!resetn || !lf_run) begin
      lf_cnt_q <= 8'h00;
      lf_clk_in <= 1'b0;
    end else if (lf_cnt_q == 8'(LF_HALF_CYC - 1)) begin
      lf_cnt_q <= 8'h00;
      lf_clk_in <= ~lf_clk_in;
    end else begin
      lf_cnt_q <= lf_cnt_q + 8'h01;
    end
  end
endmodule : pmwc_partner
`default_nettype wire

/* verif/power_mode_wake_controller_tb_top.sv */
/*
  Self-checking bench of the power-mode and wake controller: APB tasks,
  mode requests, wake events and clock selection.
  Assumes the partner model supplies oscillator settling and the slow clock.
*/
`timescale 1ns/1ps
`default_nettype none
module power_mode_wake_controller_tb_top;
  import pmwc_pkg::*;
  logic clk, resetn, por_n, reset_pin_n, psel, penable, pwrite, pready;
  logic pslverr, rtc_event, lf_xtal_fitted, hs_stable, lf_clk_in, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [NIRQ-1:0] irq;
  logic [NSC-1:0] sc_event, sc_wake_cfg;
  logic [NPIN-1:0] pin_in, pin_wake_cfg, gpio_out, io_latch, io_held;
  logic cpu_clk_en, mem_clk_en, periph_clk_en, radio_en, flash_en;
  logic sram_pwr_en, always_on_domain_en, sc_en, cpu_halt, sys_reset_n;
  logic high_speed_crystal_osc_en, high_speed_rc_osc_en, hs_doubler_en;
  logic hs_sel_rc, low_speed_crystal_osc_en, low_speed_rc_osc_en;
  logic lf_gpio_out, brownout_detector_en, por_detector_en;
  int n_fail, cmp_count, c, n, rst_low, r0;

  pmwc_ctrl i_pmwc_ctrl (
    .clk(clk), .resetn(resetn), .por_n(por_n), .reset_pin_n(reset_pin_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .rtc_event(rtc_event), .sc_event(sc_event),
    .sc_wake_cfg(sc_wake_cfg), .pin_in(pin_in),
    .pin_wake_cfg(pin_wake_cfg), .gpio_out(gpio_out),
    .lf_xtal_fitted(lf_xtal_fitted), .hs_stable(hs_stable),
    .lf_clk_in(lf_clk_in), .io_latch(io_latch), .io_held(io_held),
    .cpu_clk_en(cpu_clk_en), .mem_clk_en(mem_clk_en),
    .periph_clk_en(periph_clk_en), .radio_en(radio_en),
    .flash_en(flash_en), .sram_pwr_en(sram_pwr_en),
    .always_on_domain_en(always_on_domain_en), .sc_en(sc_en),
    .cpu_halt(cpu_halt), .sys_reset_n(sys_reset_n),
    .high_speed_crystal_osc_en(high_speed_crystal_osc_en),
    .high_speed_rc_osc_en(high_speed_rc_osc_en),
    .hs_doubler_en(hs_doubler_en), .hs_sel_rc(hs_sel_rc),
    .low_speed_crystal_osc_en(low_speed_crystal_osc_en),
    .low_speed_rc_osc_en(low_speed_rc_osc_en), .lf_gpio_out(lf_gpio_out),
    .brownout_detector_en(brownout_detector_en),
    .por_detector_en(por_detector_en)
  );

  pmwc_partner i_pmwc_partner (
    .clk(clk), .resetn(resetn),
    .high_speed_crystal_osc_en(high_speed_crystal_osc_en),
    .hs_doubler_en(hs_doubler_en),
    .high_speed_rc_osc_en(high_speed_rc_osc_en),
    .low_speed_crystal_osc_en(low_speed_crystal_osc_en),
    .low_speed_rc_osc_en(low_speed_rc_osc_en),
    .hs_stable(hs_stable), .lf_clk_in(lf_clk_in)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cycles with the core reset low are counted, so a scenario can tell a
  // full restart from a brief glitch.
  always @(negedge clk) begin
    if (sys_reset_n === 1'b0) rst_low++;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic check(input string nm, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask : check

  task automatic xfer(input logic w, input logic [11:0] a, logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready is judged at the rising edge, and the answer taken there too.
    @(posedge clk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_fail++;
        end_of_test();
      end
      @(posedge clk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wait_halt(output int cy);
    cy = 0;
    @(negedge clk);
    while (cpu_halt !== 1'b0) begin
      cy++;
      if (cy > 60000) begin
        n_fail++;
        end_of_test();
      end
      @(negedge clk);
    end
    check("hs at release", 32'(hs_stable), 32'h1);
  endtask : wait_halt

  task automatic go(input logic [1:0] r);
    xfer(1'b1, REG_CTRL, {29'h0, 1'b1, r});
    repeat (20) @(negedge clk);
  endtask : go

  task automatic wake_time(input int lo);
    check("wake time", 32'(c >= lo - 2 && c <= lo + HS_STABLE_CYC + 40),
      1);
  endtask : wake_time

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    n_fail = 0;
    cmp_count = 0;
    resetn = 1'b0;
    por_n = 1'b1;
    reset_pin_n = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    irq = '0;
    rtc_event = 1'b0;
    sc_event = '0;
    sc_wake_cfg = '0;
    pin_in = '0;
    pin_wake_cfg = 8'h01;
    gpio_out = 8'hA5;
    lf_xtal_fitted = 1'b1;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    wait_halt(c);
    xfer(1'b0, REG_RSTCAUSE, 32'h0);
    check("cause por", 32'(rdata[1:0]), 32'(CAUSE_POR));
    xfer(1'b0, REG_WAKEMASK, 32'h0);
    check("mask reset", 32'(rdata[2:0]), 32'(WMASK_RESET));
    xfer(1'b0, REG_STATUS, 32'h0);
    check("state", 32'(rdata[2:0]), 32'(ST_ACTIVE));
    xfer(1'b0, 12'h020, 32'h0);
    check("unmapped", 32'(rerr), 32'h1);
    check("lf xtal", 32'(low_speed_crystal_osc_en), 32'h1);
    check("hs xtal", 32'(hs_doubler_en & high_speed_crystal_osc_en),
      1);
    // Idle: a request without the go bit must not leave active.
    xfer(1'b1, REG_CTRL, 32'(REQ_IDLE));
    repeat (20) @(negedge clk);
    check("no go", 32'(cpu_clk_en), 32'h1);
    go(REQ_IDLE);
    check("idle", 32'({cpu_clk_en, mem_clk_en, periph_clk_en}), 1);
    r0 = rst_low;
    @(posedge clk);
    irq <= 8'h08;
    wait_halt(c);
    wake_time(WAKE_IDLE_CYC);
    check("idle resume", 32'(rst_low - r0), 32'h0);
    // Standby: interrupts and unselected sensor events must not wake.
    @(posedge clk);
    irq <= '0;
    xfer(1'b1, REG_WAKEMASK, 32'h5);
    go(REQ_STANDBY);
    check("latch", 32'({io_held, io_latch}), 32'hFFA5);
    @(posedge clk);
    gpio_out <= 8'h3C;
    irq <= 8'hFF;
    sc_event <= 4'hF;
    n = 0;
    repeat (64) begin
      @(negedge clk);
      if (brownout_detector_en === 1'b1) n++;
    end
    check("bod duty", 32'(n), 32'(BOD_ON_CYC));
    check("stby hold", 32'({io_latch, cpu_halt}),
      32'h14B);
    check("stby dom", 32'({always_on_domain_en, sc_en,
      high_speed_crystal_osc_en, high_speed_rc_osc_en,
      low_speed_crystal_osc_en, sram_pwr_en, flash_en, radio_en,
      periph_clk_en}), 32'h198);
    r0 = rst_low;
    @(posedge clk);
    irq <= '0;
    sc_event <= '0;
    rtc_event <= 1'b1;
    wait_halt(c);
    wake_time(WAKE_STBY_CYC);
    check("stby resume", 32'({rst_low != r0, io_held}), 32'h0);
    // Shutdown: only a change on a wake pin brings the device back.
    @(posedge clk);
    rtc_event <= 1'b0;
    go(REQ_SHUTDOWN);
    check("shdn latch", 32'({io_held, io_latch}), 32'hFF3C);
    check("shdn dom", 32'({always_on_domain_en, sc_en, brownout_detector_en,
      por_detector_en, sram_pwr_en, flash_en, cpu_clk_en,
      high_speed_crystal_osc_en, low_speed_crystal_osc_en,
      low_speed_rc_osc_en}), 32'h040);
    @(posedge clk);
    pin_in <= 8'h02;
    repeat (30) @(negedge clk);
    check("no pin wake", 32'(cpu_halt), 32'h1);
    r0 = rst_low;
    @(posedge clk);
    pin_in <= 8'h03;
    wait_halt(c);
    wake_time(WAKE_SHDN_CYC);
    check("shdn reset", 32'(rst_low - r0 >= WAKE_SHDN_CYC), 32'h1);
    xfer(1'b0, REG_RSTCAUSE, 32'h0);
    check("cause wake", 32'(rdata[1:0]), 32'(CAUSE_SHDN_WAKE));
    xfer(1'b0, REG_WAKEMASK, 32'h0);
    check("mask lost", 32'(rdata[2:0]), 32'(WMASK_RESET));
    // Reset pin.
    @(posedge clk);
    reset_pin_n <= 1'b0;
    repeat (10) @(negedge clk);
    check("held", 32'({cpu_halt, sys_reset_n}), 32'h2);
    @(posedge clk);
    reset_pin_n <= 1'b1;
    wait_halt(c);
    wake_time(WAKE_SHDN_CYC);
    xfer(1'b0, REG_RSTCAUSE, 32'h0);
    check("cause pin", 32'(rdata[1:0]), 32'(CAUSE_PIN_RESET));
    // Clock sources.
    xfer(1'b1, REG_CLKSEL, 32'h3);
    repeat (4) @(negedge clk);
    check("hs rc", 32'({hs_sel_rc, high_speed_rc_osc_en}), 32'h3);
    for (int lv = 1; lv >= 0; lv--) begin
      n = 0;
      while (lf_clk_in !== 1'(lv) && n < 40) begin
        @(negedge clk);
        n++;
      end
      repeat (3) @(negedge clk);
      check("lf out", 32'(lf_gpio_out), 32'(lv));
    end
    @(posedge clk);
    lf_xtal_fitted <= 1'b0;
    repeat (4) @(negedge clk);
    check("lf rc", 32'({low_speed_rc_osc_en, low_speed_crystal_osc_en}),
      32'h2);
    end_of_test();
  end
endmodule : power_mode_wake_controller_tb_top
`default_nettype wire
